// ---- hw/spi_flash_pkg.sv ----
// constants, types and the rule summary for the serial flash read path
// Contract
// - single reads: command on SI, data on SO
// - 8-bit opcode MSB first: 03h, 0Bh, 3Bh
// - 24-bit start address follows, bit 23 first
// - 0Bh adds one dummy byte; 03h none
// - host uses 03h only at low rate
// - single data bytes shift out bit 7 first
// - read address advances after every byte
// - chip select release aborts, SO released
// - top address wraps to zero, no wait
// - dual read: command on SI, dummy byte
// - SI turns output after address phase; the device waits out the dummy byte first
// - dual: four clocks per byte, bits paired
// - release in dual frees SO and SI
// - host sets length by clocking time
package spi_flash_pkg;

   // opcodes of the array read commands
   localparam logic [7:0]  OP_READ       = 8'h03;
   localparam logic [7:0]  OP_FAST       = 8'h0B;
   localparam logic [7:0]  OP_DUAL       = 8'h3B;

   // field lengths in serial clocks
   localparam int          OP_BITS       = 8;
   localparam int          ADDR_BITS     = 24;
   localparam int          DUMMY_BITS    = 8;
   localparam int          BYTE_BITS     = 8;
   localparam int          DUAL_CLKS     = 4;

   // array geometry
   localparam int          ARRAY_AW      = 19;
   localparam logic [23:0] ARRAY_TOP     = 24'h07FFFF;
   localparam logic [23:0] ARRAY_BASE    = 24'h000000;

   // host serial clock half periods in clk_sys cycles; 3 is the least
   // because returning data passes a two-stage synchroniser
   localparam int          SCK_HALF_FAST = 4;
   localparam int          SCK_HALF_SLOW = 8;

   typedef enum logic [1:0] {RD_PLAIN, RD_FAST, RD_DUAL} read_kind_e;

endpackage

// ---- hw/spi_flash_if.sv ----
// pins between the flash read host and the flash read device
`timescale 1ns/1ps
interface spi_flash_if;
   logic csN;
   logic sck;
   logic siHost;
   logic siHostOe;
   logic siDev;
   logic siDevOe;
   logic soDev;
   logic soOe;
   logic siLine;
   logic soLine;

   // wire levels from the enables; undriven lines float high
   assign siLine = siHostOe ? siHost : (siDevOe ? siDev : 1'b1);
   assign soLine = soOe ? soDev : 1'b1;

   modport host (output csN, sck, siHost, siHostOe, input siLine, soLine);
   modport dev  (input csN, sck, siLine, output siDev, siDevOe, soDev, soOe);
endinterface

// ---- hw/flash_read_dev.sv ----
// device end: command decode, address counter and serial data launch
`timescale 1ns/1ps
module flash_read_dev
   import spi_flash_pkg::*;
#(
   parameter int AW = ARRAY_AW
)
(
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   spi_flash_if.dev           link,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [7:0]    wrData,
   output logic               linkBusy
);

   typedef enum {PH_OP, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} link_phase_e;

   localparam logic [AW-1:0] TOP  = AW'(ARRAY_TOP);
   localparam logic [AW-1:0] BASE = AW'(ARRAY_BASE);
   localparam logic [4:0]    OP_LAST    = 5'(OP_BITS - 1);
   localparam logic [4:0]    ADDR_LAST  = 5'(ADDR_BITS - 1);
   localparam logic [4:0]    DUMMY_LAST = 5'(DUMMY_BITS - 1);
   localparam logic [4:0]    BYTE_LAST  = 5'(BYTE_BITS - 1);
   localparam logic [4:0]    DUAL_LAST  = 5'(DUAL_CLKS - 1);

   // array contents, loaded from the system side
   logic [7:0]    mem [0:(1<<AW)-1];

   // rising-edge link state
   link_phase_e   phase;
   link_phase_e   next_phase;
   logic [4:0]    cnt;
   logic [4:0]    next_cnt;
   logic [7:0]    opSh;
   logic [7:0]    next_opSh;
   logic [23:0]   addrSh;
   logic [23:0]   next_addrSh;
   logic [AW-1:0] addr;
   logic [AW-1:0] next_addr;
   logic          fast;
   logic          next_fast;
   logic          dual;
   logic          next_dual;

   // falling-edge launch state
   logic [7:0]    outSh;
   logic [7:0]    next_outSh;
   logic          soDrv;
   logic          next_soDrv;
   logic          siDrv;
   logic          next_siDrv;
   logic          soEn;
   logic          next_soEn;
   logic          siEn;
   logic          next_siEn;

   // system-side status
   logic          csSync1;
   logic          csSync2;
   logic          next_linkBusy;

   // array write port; reads happen in the link domain only
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
         mem[wrAddr] <= wrData;
   end

   // command, address and byte counting on rising edges
   always_comb
   begin
      next_phase  = phase;
      next_cnt    = cnt + 5'h01;
      next_opSh   = opSh;
      next_addrSh = addrSh;
      next_addr   = addr;
      next_fast   = fast;
      next_dual   = dual;
      case (phase)
         PH_OP:
         begin
            next_opSh = {opSh[6:0], link.siLine};
            if (cnt == OP_LAST)
            begin
               next_cnt = 5'h00;
               if (next_opSh == OP_READ)
               begin
                  next_phase = PH_ADDR;
                  next_fast  = 1'b0;
                  next_dual  = 1'b0;
               end
               else if (next_opSh == OP_FAST)
               begin
                  next_phase = PH_ADDR;
                  next_fast  = 1'b1;
                  next_dual  = 1'b0;
               end
               else if (next_opSh == OP_DUAL)
               begin
                  next_phase = PH_ADDR;
                  next_fast  = 1'b1;
                  next_dual  = 1'b1;
               end
               else
                  next_phase = PH_IGNORE;  // other commands are not this block's
            end
         end
         PH_ADDR:
         begin
            next_addrSh = {addrSh[22:0], link.siLine};
            if (cnt == ADDR_LAST)
            begin
               next_cnt   = 5'h00;
               next_addr  = next_addrSh[AW-1:0];  // upper bits beyond the array drop
               next_phase = fast ? PH_DUMMY : PH_DATA;
            end
         end
         PH_DUMMY:
         begin
            if (cnt == DUMMY_LAST)
            begin
               next_cnt   = 5'h00;
               next_phase = PH_DATA;
            end
         end
         PH_DATA:
         begin
            // one byte is eight clocks single, four clocks dual
            if (cnt == (dual ? DUAL_LAST : BYTE_LAST))
            begin
               next_cnt  = 5'h00;
               next_addr = (addr == TOP) ? BASE : addr + 1'b1;
            end
         end
         default:
            next_cnt = cnt;
      endcase
   end

   // chip select high holds the link logic in its idle state
   always_ff @(posedge link.sck or posedge link.csN)
   begin
      if (link.csN)
      begin
         phase  <= PH_OP;
         cnt    <= 5'h00;
         opSh   <= 8'h00;
         addrSh <= 24'h000000;
         addr   <= '0;
         fast   <= 1'b0;
         dual   <= 1'b0;
      end
      else
      begin
         phase  <= next_phase;
         cnt    <= next_cnt;
         opSh   <= next_opSh;
         addrSh <= next_addrSh;
         addr   <= next_addr;
         fast   <= next_fast;
         dual   <= next_dual;
      end
   end

   // data launch on falling edges; a byte is fetched when cnt is zero
   always_comb
   begin
      logic [7:0] word;
      word       = mem[addr];
      next_outSh = outSh;
      next_soDrv = soDrv;
      next_siDrv = siDrv;
      next_soEn  = 1'b0;
      next_siEn  = 1'b0;
      if (phase == PH_DATA)
      begin
         next_soEn = 1'b1;
         // SI stays an input through the dummy byte, the host drives it
         next_siEn = dual;
         if (cnt == 5'h00)
         begin
            next_soDrv = word[7];
            if (dual)
            begin
               next_siDrv = word[6];
               next_outSh = {word[5:0], 2'b00};
            end
            else
               next_outSh = {word[6:0], 1'b0};
         end
         else
         begin
            next_soDrv = outSh[7];
            if (dual)
            begin
               next_siDrv = outSh[6];
               next_outSh = {outSh[5:0], 2'b00};
            end
            else
               next_outSh = {outSh[6:0], 1'b0};
         end
      end
   end

   // release is asynchronous so the pins free at once, even mid-byte
   always_ff @(negedge link.sck or posedge link.csN)
   begin
      if (link.csN)
      begin
         outSh <= 8'h00;
         soDrv <= 1'b0;
         siDrv <= 1'b0;
         soEn  <= 1'b0;
         siEn  <= 1'b0;
      end
      else
      begin
         outSh <= next_outSh;
         soDrv <= next_soDrv;
         siDrv <= next_siDrv;
         soEn  <= next_soEn;
         siEn  <= next_siEn;
      end
   end

   assign link.soDev   = soDrv;
   assign link.soOe    = soEn;
   assign link.siDev   = siDrv;
   assign link.siDevOe = siEn;

   // chip select into the system domain through two stages
   always_comb
   begin
      next_linkBusy = ~csSync2;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         csSync1  <= 1'b1;
         csSync2  <= 1'b1;
         linkBusy <= 1'b0;
      end
      else
      begin
         csSync1  <= link.csN;
         csSync2  <= csSync1;
         linkBusy <= next_linkBusy;
      end
   end

endmodule // flash_read_dev

// ---- hw/flash_read_host.sv ----
// host end: makes the serial clock and runs one array read per request
`timescale 1ns/1ps
module flash_read_host
   import spi_flash_pkg::*;
#(
   parameter int HALF_FAST = SCK_HALF_FAST,
   parameter int HALF_SLOW = SCK_HALF_SLOW,
   parameter int CNT_W     = 20
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   spi_flash_if.host             link,
   input  wire logic             start,
   input  read_kind_e            kind,
   input  wire logic [23:0]      startAddr,
   input  wire logic [CNT_W-1:0] byteCount,
   output logic                  busy,
   output logic [7:0]            rxData,
   output logic                  rxValid,
   output logic                  done
);

   typedef enum {H_IDLE, H_TX, H_RX, H_END} host_state_e;

   host_state_e      state, next_state;
   logic [7:0]       div, next_div, half, next_half;
   logic             sck, next_sck, csN, next_csN;
   logic             siOut, next_siOut, siOe, next_siOe;
   logic [39:0]      txSh, next_txSh;
   logic [5:0]       txLeft, next_txLeft;
   logic [7:0]       rxSh, next_rxSh;
   logic [3:0]       rxBit, next_rxBit;
   logic [CNT_W-1:0] left, next_left;
   logic             dualMode, next_dualMode;
   logic             next_busy, next_rxValid, next_done;
   logic [7:0]       next_rxData;
   logic             so1, so2, si1, si2;

   // one transfer: header out, then bytes in until the count runs out
   always_comb
   begin
      logic       tick;
      logic [7:0] opc;
      tick          = (div == half - 8'h01);
      opc           = (kind == RD_PLAIN) ? OP_READ : (kind == RD_FAST) ? OP_FAST : OP_DUAL;
      next_state    = state;
      next_div      = tick ? 8'h00 : div + 8'h01;
      next_half     = half;
      next_sck      = sck;
      next_csN      = csN;
      next_siOut    = siOut;
      next_siOe     = siOe;
      next_txSh     = txSh;
      next_txLeft   = txLeft;
      next_rxSh     = rxSh;
      next_rxBit    = rxBit;
      next_left     = left;
      next_dualMode = dualMode;
      next_busy     = busy;
      next_rxData   = rxData;
      next_rxValid  = 1'b0;
      next_done     = 1'b0;
      case (state)
         H_IDLE:
         begin
            next_div = 8'h00;
            if (start && byteCount != '0)
            begin
               next_state    = H_TX;
               next_csN      = 1'b0;
               next_busy     = 1'b1;
               // plain read runs on the slower clock only
               next_half     = 8'((kind == RD_PLAIN) ? HALF_SLOW : HALF_FAST);
               next_dualMode = (kind == RD_DUAL);
               next_txSh     = {opc, startAddr, 8'h00};
               next_siOut    = opc[7];
               next_siOe     = 1'b1;
               next_txLeft   = 6'((kind == RD_PLAIN) ? (OP_BITS + ADDR_BITS)
                                  : (OP_BITS + ADDR_BITS + DUMMY_BITS));
               next_left     = byteCount;
               next_rxBit    = 4'h0;
            end
         end
         H_TX:
         begin
            if (tick)
            begin
               next_sck = ~sck;
               if (!sck)
                  next_txLeft = txLeft - 6'h01;
               else if (txLeft == 6'h00)
               begin
                  // free SI on the falling edge; dropping it with the last rising
                  // edge would race the device's sample of the final header bit
                  next_siOe  = 1'b0;
                  next_state = H_RX;
               end
               else
               begin
                  next_txSh  = {txSh[38:0], 1'b0};
                  next_siOut = txSh[38];
               end
            end
         end
         H_RX:
         begin
            if (tick)
            begin
               next_sck = ~sck;
               if (!sck)
               begin
                  next_rxSh  = dualMode ? {rxSh[5:0], so2, si2} : {rxSh[6:0], so2};
                  next_rxBit = rxBit + 4'h1;
                  if (rxBit == (dualMode ? 4'(DUAL_CLKS - 1) : 4'(BYTE_BITS - 1)))
                  begin
                     next_rxBit   = 4'h0;
                     next_rxData  = next_rxSh;
                     next_rxValid = 1'b1;
                     next_left    = left - 1'b1;
                     if (left == CNT_W'(1))
                        next_state = H_END;
                  end
               end
            end
         end
         H_END:
         begin
            if (tick)
            begin
               if (sck)
                  next_sck = 1'b0;
               else
               begin
                  next_csN   = 1'b1;
                  next_busy  = 1'b0;
                  next_done  = 1'b1;
                  next_state = H_IDLE;
               end
            end
         end
         default:
            next_state = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         state    <= H_IDLE;
         div      <= 8'h00;
         half     <= 8'(HALF_FAST);
         sck      <= 1'b0;
         csN      <= 1'b1;
         siOut    <= 1'b0;
         siOe     <= 1'b0;
         txSh     <= 40'h0000000000;
         txLeft   <= 6'h00;
         rxSh     <= 8'h00;
         rxBit    <= 4'h0;
         left     <= '0;
         dualMode <= 1'b0;
         busy     <= 1'b0;
         rxData   <= 8'h00;
         rxValid  <= 1'b0;
         done     <= 1'b0;
         so1      <= 1'b1;
         so2      <= 1'b1;
         si1      <= 1'b1;
         si2      <= 1'b1;
      end
      else
      begin
         state    <= next_state;
         div      <= next_div;
         half     <= next_half;
         sck      <= next_sck;
         csN      <= next_csN;
         siOut    <= next_siOut;
         siOe     <= next_siOe;
         txSh     <= next_txSh;
         txLeft   <= next_txLeft;
         rxSh     <= next_rxSh;
         rxBit    <= next_rxBit;
         left     <= next_left;
         dualMode <= next_dualMode;
         busy     <= next_busy;
         rxData   <= next_rxData;
         rxValid  <= next_rxValid;
         done     <= next_done;
         so1      <= link.soLine;  // returning data passes two stages
         so2      <= so1;
         si1      <= link.siLine;
         si2      <= si1;
      end
   end

   assign link.csN      = csN;
   assign link.sck      = sck;
   assign link.siHost   = siOut;
   assign link.siHostOe = siOe;

endmodule // flash_read_host

// ---- testbench/serial_flash_array_read_checker.sv ----
// wire-level checks between the flash read host and device
`timescale 1ns/1ps
module serial_flash_array_read_checker
   import spi_flash_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic csN,
   input wire logic sck,
   input wire logic siHost,
   input wire logic siHostOe,
   input wire logic siDevOe,
   input wire logic soDev,
   input wire logic soOe
);
   logic        sckQ;
   logic [15:0] edges;
   logic [15:0] next_edges;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // rising serial clock edges seen in the current frame
   always_comb
   begin
      next_edges = csN ? 16'h0000 : edges + {15'h0000, (sck && !sckQ)};
   end

   // sck is a host flop on clk_sys, so one sample per level is enough
   always_ff @(posedge clk_sys)
   begin
      sckQ  <= sck;
      edges <= next_edges;
   end

   AST_SO_RELEASE: assert property (csN |-> !soOe)
      else $error("output line driven while deselected");
   AST_SI_RELEASE: assert property (csN |-> !siDevOe)
      else $error("input line driven by device while deselected");
   AST_NO_CONTENTION: assert property (!(siHostOe && siDevOe))
      else $error("both ends drive the input line");
   AST_DUAL_PAIR: assert property (siDevOe |-> soOe)
      else $error("dual data without output line");
   AST_LAUNCH_FALL: assert property ($changed(soDev) && !csN |-> !sck)
      else $error("output bit changed while clock high");
   AST_HOST_FALL: assert property ($changed(siHost) |-> !sck)
      else $error("host input bit changed while clock high");
   AST_SO_START: assert property ($rose(soOe) |-> (edges == 16'h0020 || edges == 16'h0028))
      else $error("data started after wrong header length");
   AST_DUAL_START: assert property ($rose(siDevOe) |-> edges == 16'h0028)
      else $error("dual turnaround at wrong clock");
   AST_TURN: assert property (soOe |-> !siHostOe)
      else $error("host still drives input during data");

   COV_DUAL: cover property ($rose(siDevOe));
   COV_PLAIN: cover property ($rose(soOe) && edges == 16'h0020);
   COV_FRAME: cover property ($fell(csN));
endmodule // serial_flash_array_read_checker

// ---- testbench/serial_flash_array_read_tb_top.sv ----
// self-checking bench: host and device joined across the link
`timescale 1ns/1ps
module serial_flash_array_read_tb_top;
   import spi_flash_pkg::*;

   logic        clk_sys;
   logic        rst_b;
   logic        start;
   read_kind_e  kind;
   logic [23:0] startAddr;
   logic [19:0] byteCount;
   logic        busy;
   logic [7:0]  rxData;
   logic        rxValid;
   logic        done;
   logic        wrEn;
   logic [18:0] wrAddr;
   logic [7:0]  wrData;
   logic        linkBusy;
   logic [7:0]  opSeen;
   int          sckEdges;
   time         sckLast;
   time         sckMin;
   int          n_fail;
   int          checks;
   int          seed;

   spi_flash_if link ();

   flash_read_host flash_read_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
      .start(start), .kind(kind), .startAddr(startAddr), .byteCount(byteCount),
      .busy(busy), .rxData(rxData), .rxValid(rxValid), .done(done));

   flash_read_dev flash_read_dev_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .linkBusy(linkBusy));

   serial_flash_array_read_checker serial_flash_array_read_checker_i (.clk_sys(clk_sys),
      .rst_b(rst_b), .csN(link.csN), .sck(link.sck), .siHost(link.siHost),
      .siHostOe(link.siHostOe), .siDevOe(link.siDevOe), .soDev(link.soDev),
      .soOe(link.soOe));

   // 10 MHz system clock; the link clock is divided down by the host
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // array content as a function of address, so neighbours differ except where the low 16 bits go from 7FFFh to 8000h
   function automatic logic [7:0] pat(input logic [18:0] a);
      return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'hA5;
   endfunction

   function automatic logic [7:0] op_of(input read_kind_e k);
      return (k == RD_PLAIN) ? OP_READ : ((k == RD_FAST) ? OP_FAST : OP_DUAL);
   endfunction

   // wire monitor: opcode bits and rising clock count per frame
   always @(posedge link.sck)
   begin
      if (!link.csN)
      begin
         if (sckEdges < 8)
            opSeen = {opSeen[6:0], link.siLine};
         // shortest rising-to-rising spacing in the frame
         if (sckEdges > 0 && $time - sckLast < sckMin)
            sckMin = $time - sckLast;
         sckLast = $time;
         sckEdges++;
      end
   end

   task automatic chk(input logic ok, input string msg);
      checks++;
      if (!ok)
      begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // load the bytes to be read, then run one read and compare the stream
   task automatic rd(input read_kind_e k, input logic [23:0] a, input int n);
      logic [18:0] p;
      int          got;
      int          t;
      got = 0;
      for (int i = 0; i < n; i++)
      begin
         p = a[18:0] + i[18:0];
         @(posedge clk_sys);
         wrEn   <= 1'b1;
         wrAddr <= p;
         wrData <= pat(p);
      end
      @(posedge clk_sys);
      wrEn      <= 1'b0;
      sckEdges  = 0;
      sckMin    = 64'h00000000FFFFFFFF;
      start     <= 1'b1;
      kind      <= k;
      startAddr <= a;
      byteCount <= n[19:0];
      @(posedge clk_sys);
      startAddr <= a ^ 24'h000F0F; // a second start while busy must be ignored
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      chk(busy === 1'b1, "busy not raised");
      for (t = 0; t < 20000 && done !== 1'b1; t++)
      begin
         @(posedge clk_sys);
         #1;
         if (rxValid === 1'b1)
         begin
            p = a[18:0] + got[18:0];
            chk(rxData === pat(p), "data byte wrong");
            chk(linkBusy === 1'b1, "device not busy in frame");
            got++;
         end
      end
      chk(got == n, "byte count wrong");
      chk(busy === 1'b0, "busy still high after done");
      chk(opSeen === op_of(k), "opcode on wire wrong");
      chk(sckEdges == ((k == RD_PLAIN) ? 32 : 40) + n * ((k == RD_DUAL) ? 4 : 8),
          "clock count wrong");
      chk(k != RD_PLAIN || sckMin >= 2 * SCK_HALF_SLOW * 100, "plain read clock too fast");
      chk(link.soLine === 1'b1 && link.siLine === 1'b1, "lines not released");
   endtask

   initial
   begin
      seed      = 95552;
      rst_b     = 1'b0;
      start     = 1'b0;
      kind      = RD_PLAIN;
      startAddr = 24'h000000;
      byteCount = 20'h00000;
      wrEn      = 1'b0;
      wrAddr    = 19'h00000;
      wrData    = 8'h00;
      opSeen    = 8'h00;
      sckEdges  = 0;
      n_fail    = 0;
      checks    = 0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      // zero length request is refused
      @(posedge clk_sys);
      start     <= 1'b1;
      byteCount <= 20'h00000;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(busy === 1'b0 && link.csN === 1'b1, "zero count started a frame");
      // every kind: single byte, wrap at the top, then random spans
      for (int k = 0; k < 3; k++)
      begin
         rd(read_kind_e'(k), 24'h000000, 1);
         rd(read_kind_e'(k), 24'h07FFFE, 4);
         for (int r = 0; r < 3; r++)
            rd(read_kind_e'(k), 24'($random(seed)) & 24'h07FFFF, 1 + {$random(seed)} % 4);
      end
      tally_and_finish();
   end

   // hang guard, well above the longest expected run
   initial
   begin
      #6000000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // serial_flash_array_read_tb_top
